/* design/tli_defs.svh */
// constants for the table lookup and interpolate datapath
`ifndef TLI_DEFS_SVH
`define TLI_DEFS_SVH
`define TLI_IDX_MSB      15
`define TLI_IDX_LSB      8
`define TLI_FRAC_MSB     7
`define TLI_FRAC_LSB     0
`define TLI_FRAC_BITS    8
`define TLI_FRAC_SCALE   256
`define TLI_LATENCY      2
`endif

/* design/tli_pkg.sv */
// types for the table lookup and interpolate datapath
package tli_pkg;
    typedef enum logic [1:0]
    {
        TLI_SIGNED_ROUNDED    = 2'h0,
        TLI_SIGNED_UNROUNDED  = 2'h1,
        TLI_UNSIGNED_ROUNDED  = 2'h2,
        TLI_UNSIGNED_UNROUNDED = 2'h3
    } tli_variant_e;

    typedef enum logic [1:0]
    {
        TLI_SIZE_BYTE = 2'h0,
        TLI_SIZE_WORD = 2'h1,
        TLI_SIZE_LONG = 2'h3
    } tli_size_e;

    typedef enum logic [1:0]
    {
        TLI_IDLE = 2'h0,
        TLI_CALC = 2'h1,
        TLI_DONE = 2'h3
    } tli_state_e;

    typedef struct packed
    {
        tli_variant_e variant;
        tli_size_e    size;
        logic         reg_pair;
        logic [31:0]  index_fraction_reg;
        logic [31:0]  surface_fraction_reg;
        logic [31:0]  entry_lo;
        logic [31:0]  entry_hi;
    } tli_req_s;

    typedef struct packed
    {
        logic [31:0] result;
        logic [7:0]  entry_index;
    } tli_rsp_s;

    typedef struct packed
    {
        tli_state_e  state;
        logic        sgn;
        logic        rnd;
        tli_size_e   size;
        logic [7:0]  frac;
        logic [40:0] lo;
        logic [40:0] diff;
        logic [40:0] acc;
        logic [31:0] result;
        logic [7:0]  idx;
        logic        done;
    } tli_state_s;
endpackage

/* design/tli_unit.sv */
// table lookup and linear interpolation datapath
// Notes on behaviour
// - index bits 15:8, fraction bits 7:0
// - result is lo plus frac times diff over 256
// - signed rounded: nearest, ties to even
// - unrounded: keep 8-bit fraction in low bits
// - register pair: fraction from separate register
// - four variants, byte word long results
// - memory table or register pair data
`timescale 1ns/1ps
`include "tli_defs.svh"
module tli_unit
(
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              start,
    input  wire tli_pkg::tli_req_s req,
    output logic                   busy,
    output logic                   done,
    output tli_pkg::tli_rsp_s      rsp
);
    import tli_pkg::*;

    // all block state lives in st_reg; only the reset flops stand apart
    logic [1:0]  rst_sync_reg;
    logic        rst_n_int;
    tli_state_s  st_reg;
    tli_state_s  st_next;

    logic        fresh_sgn;
    logic [40:0] fresh_lo;
    logic [40:0] fresh_hi;
    logic [40:0] rounded;
    tli_size_e   unr_size;

    // reset state: idle, no result held, done low
    localparam tli_state_s ST_RESET = '0;

    // reset released through two flops, asserted at once, so that
    // release never meets an edge half way through the state flops
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_sync_reg <= 2'h0;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_reg[1];

    // extends an operand of the given size to 41 bits; 41 bits hold a
    // signed long scaled by 256 without losing its sign
    function automatic logic [40:0] ext(input logic [31:0] v,
                                        input tli_size_e sz,
                                        input logic s);
        logic [40:0] r;
        r = 41'h0;
        case (sz)
            TLI_SIZE_BYTE: r = {{33{s & v[7]}}, v[7:0]};
            TLI_SIZE_WORD: r = {{25{s & v[15]}}, v[15:0]};
            TLI_SIZE_LONG: r = {{9{s & v[31]}}, v};
            default:       r = {{9{s & v[31]}}, v};
        endcase
        return r;
    endfunction

    // truncates to operation size, upper bits zero
    function automatic logic [31:0] fit(input logic [40:0] v,
                                        input tli_size_e sz);
        logic [31:0] r;
        r = 32'h0;
        case (sz)
            TLI_SIZE_BYTE: r = {24'h0, v[7:0]};
            TLI_SIZE_WORD: r = {16'h0, v[15:0]};
            default:       r = v[31:0];
        endcase
        return r;
    endfunction

    // unrounded results keep eight fraction bits, so they need the
    // next size up; a long result loses its top byte instead
    function automatic tli_size_e widen(input tli_size_e sz);
        tli_size_e r;
        r = TLI_SIZE_LONG;
        case (sz)
            TLI_SIZE_BYTE: r = TLI_SIZE_WORD;
            TLI_SIZE_WORD: r = TLI_SIZE_LONG;
            default:       r = TLI_SIZE_LONG;
        endcase
        return r;
    endfunction

    // drops the fraction: nearest integer, exact halves go to even,
    // so repeated lookups do not drift upward on average
    function automatic logic [40:0] round_even(input logic [40:0] a,
                                               input logic s);
        logic [40:0] q;
        logic [7:0]  f;
        q = {{8{a[40] & s}}, a[40:8]};
        f = a[7:0];
        if (f > 8'h80 || (f == 8'h80 && q[0]))
        begin
            q = q + 41'h1;
        end
        return q;
    endfunction

    // operands are extended at the take edge; req need not stand later
    always_comb
    begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        fresh_sgn    = (req.variant == TLI_SIGNED_ROUNDED) ||
                       (req.variant == TLI_SIGNED_UNROUNDED);
        fresh_lo     = ext(req.entry_lo, req.size, fresh_sgn);
        fresh_hi     = ext(req.entry_hi, req.size, fresh_sgn);
        unr_size     = widen(st_reg.size);
        rounded      = round_even(st_reg.acc, st_reg.sgn);

        case (st_reg.state)
            TLI_IDLE:
            begin
                // a start while busy is dropped with no flag raised
                if (start)
                begin
                    st_next.state = TLI_CALC;
                    st_next.sgn   = fresh_sgn;
                    st_next.rnd   = (req.variant == TLI_SIGNED_ROUNDED) ||
                                    (req.variant == TLI_UNSIGNED_ROUNDED);
                    st_next.size  = req.size;
                    if (req.reg_pair)
                    begin
                        st_next.frac = req.surface_fraction_reg[
                            `TLI_FRAC_MSB:`TLI_FRAC_LSB];
                    end
                    else
                    begin
                        st_next.frac = req.index_fraction_reg[
                            `TLI_FRAC_MSB:`TLI_FRAC_LSB];
                    end
                    // index only echoed back; the fetch itself is outside
                    st_next.idx  = req.index_fraction_reg[
                        `TLI_IDX_MSB:`TLI_IDX_LSB];
                    st_next.lo   = fresh_lo;
                    st_next.diff = fresh_hi - fresh_lo;
                end
            end

            TLI_CALC:
            begin
                // lo*256 + frac*diff keeps the 8-bit fraction; the
                // product is signed as diff may fall even when unsigned
                st_next.acc   = (st_reg.lo << `TLI_FRAC_BITS)
                    + 41'($signed(st_reg.diff) *
                          $signed({1'b0, st_reg.frac}));
                st_next.state = TLI_DONE;
            end

            TLI_DONE:
            begin
                // done and result are registered on the same edge
                st_next.done  = 1'b1;
                st_next.state = TLI_IDLE;
                if (st_reg.frac == 8'h00)
                begin
                    // no rounding step; rounded variants return the entry untouched, unrounded shift it up 8 bits
                    if (st_reg.rnd)
                    begin
                        st_next.result = fit(st_reg.lo, st_reg.size);
                    end
                    else
                    begin
                        st_next.result = fit(st_reg.lo << `TLI_FRAC_BITS,
                                             unr_size);
                    end
                end
                else if (st_reg.rnd)
                begin
                    st_next.result = fit(rounded, st_reg.size);
                end
                else
                begin
                    st_next.result = fit(st_reg.acc, unr_size);
                end
            end

            default:
            begin
                st_next.state = TLI_IDLE;
            end
        endcase
    end

    // the only clocked state besides the reset flops: one register of the whole struct
    always_ff @(posedge mclk or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            st_reg <= ST_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // busy comes straight from state so a refused start shows at once
    assign busy            = (st_reg.state != TLI_IDLE);
    assign done            = st_reg.done;
    assign rsp.result      = st_reg.result;
    assign rsp.entry_index = st_reg.idx;
endmodule

/* test/tli_unit_props.sv */
// concurrent checks on the table lookup and interpolate ports
`timescale 1ns/1ps
module tli_unit_props
(
    input wire logic              mclk,
    input wire logic              reset_n,
    input wire logic              start,
    input wire tli_pkg::tli_req_s req,
    input wire logic              busy,
    input wire logic              done,
    input wire tli_pkg::tli_rsp_s rsp
);
    import tli_pkg::*;
    logic [1:0] up_reg;
    logic       take;
    logic       z;
    // reset leaves through two flops, so early starts are not taken
    always_ff @(posedge mclk or negedge reset_n)
        if (!reset_n)
            up_reg <= 2'h0;
        else if (up_reg != 2'h3)
            up_reg <= up_reg + 2'h1;
    assign take = start && !busy && up_reg >= 2'h2;
    assign z = take && req.size == TLI_SIZE_LONG && (req.reg_pair ?
        req.surface_fraction_reg[7:0] : req.index_fraction_reg[7:0]) == 8'h0;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    AST_DONE_LAT: assert property (take |-> ##3 done)
        else $error("done late or missing");
    AST_BUSY: assert property (take |=> busy[*2] ##1 !busy)
        else $error("busy span wrong");
    AST_PULSE: assert property (done |=> !done)
        else $error("done longer than one cycle");
    AST_INDEX: assert property (take |-> ##3 rsp.entry_index ==
        $past(req.index_fraction_reg[15:8], 3)) else $error("bad index");
    AST_ZERO_RND: assert property (z && !req.reg_pair &&
        !req.variant[0] |-> ##3 rsp.result == $past(req.entry_lo, 3))
        else $error("zero fraction not entry");
    AST_ZERO_UNR: assert property (z && req.variant[0] |-> ##3
        rsp.result == {$past(req.entry_lo[23:0], 3), 8'h00})
        else $error("unrounded zero fraction wrong");
    AST_PAIR: assert property (z && req.reg_pair &&
        !req.variant[0] |-> ##3 rsp.result == $past(req.entry_lo, 3))
        else $error("pair fraction source wrong");
    AST_BYTE: assert property (take && req.size == TLI_SIZE_BYTE
        |-> ##3 rsp.result[31:16] == 16'h0 && ($past(req.variant[0], 3)
        || rsp.result[15:8] == 8'h0)) else $error("byte upper set");
endmodule
bind tli_unit tli_unit_props u_props (.mclk(mclk), .reset_n(reset_n),
    .start(start), .req(req), .busy(busy), .done(done), .rsp(rsp));

/* test/testbench.sv */
// self-checking bench for the table lookup and interpolate datapath
`timescale 1ns/1ps
module testbench;
    import tli_pkg::*;
    localparam tli_variant_e VSR = TLI_SIGNED_ROUNDED;
    localparam tli_variant_e VSU = TLI_SIGNED_UNROUNDED;
    localparam tli_variant_e VUR = TLI_UNSIGNED_ROUNDED;
    localparam tli_variant_e VUU = TLI_UNSIGNED_UNROUNDED;
    localparam tli_size_e    SB  = TLI_SIZE_BYTE;
    localparam tli_size_e    SW  = TLI_SIZE_WORD;
    localparam tli_size_e    SL  = TLI_SIZE_LONG;
    logic     mclk = 1'b0;
    logic     reset_n = 1'b0;
    logic     start = 1'b0;
    tli_req_s req = '0;
    logic     busy;
    logic     done;
    tli_rsp_s rsp;
    int       err_total = 0;
    int       cmp_count = 0;
    always #20 mclk = ~mclk;
    tli_unit DUT (.mclk(mclk), .reset_n(reset_n), .start(start),
        .req(req), .busy(busy), .done(done), .rsp(rsp));
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t result %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(logic got, logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t done flag %b want %b", $time, got, exp);
        end
    endtask
    task automatic run(tli_variant_e v, tli_size_e s, logic p,
                       logic [31:0] x, m, lo, hi, e);
        int n;
        n = 0;
        @(posedge mclk);
        req <= '{v, s, p, x, m, lo, hi};
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        #1;
        while (done !== 1'b1 && n < 9)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk_flag(done, 1'b1);
        chk(rsp.result, e);
        chk({24'h0, rsp.entry_index}, {24'h0, x[15:8]});
    endtask
    task automatic t_examples;
        run(VUR,SW,1'h0,32'hA380,32'h0,32'h685,32'h68F,32'h68A);
        run(VSR,SL,1'h0,32'h028E,32'h0,32'h51F,32'h7AE,32'h68A);
        run(VSU,SL,1'h0,32'h028E,32'h0,32'h51F,32'h7AE,32'h68A52);
        run(VSU,SL,1'h0,32'h0BD0,32'h0,32'h50,32'h40,32'h4300);
    endtask
    task automatic t_round;
        run(VSR,SB,1'h0,32'h0080,32'h0,32'h0,32'h1,32'h0);
        run(VSR,SB,1'h0,32'h0180,32'h0,32'h1,32'h2,32'h2);
    endtask
    task automatic t_variants;
        run(VUR,SB,1'h0,32'h0080,32'h0,32'hF0,32'h10,32'h80);
        run(VSR,SB,1'h0,32'h0080,32'h0,32'hF0,32'h10,32'h0);
        run(VSR,SB,1'h0,32'h0040,32'h0,32'hF0,32'hE0,32'hEC);
        run(VUU,SL,1'h0,32'h0040,32'h0,32'h10,32'h20,32'h1400);
    endtask
    task automatic t_pair;
        run(VSR,SL,1'h1,32'h0000,32'h80,32'h1,32'h3,32'h2);
        run(VSR,SL,1'h1,32'h0080,32'h0,32'h5,32'h9,32'h5);
        run(VUR,SW,1'h1,32'h0000,32'h80,32'h100,32'h300,32'h200);
        run(VSU,SB,1'h0,32'h0080,32'h0,32'h10,32'h20,32'h1800);
        run(VSU,SB,1'h0,32'h0080,32'h0,32'h30,32'h40,32'h3800);
        run(VSR,SW,1'h1,32'h0000,32'h40,32'h1800,32'h3800,32'h2000);
    endtask
    task automatic t_zero;
        run(VUR,SL,1'h0,32'hFF00,32'h0,32'hABCDEF,32'h0,32'hABCDEF);
        run(VUU,SL,1'h0,32'h0100,32'h0,32'h1234,32'h1,32'h123400);
    endtask
    task automatic print_verdict;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_examples;
        t_round;
        t_variants;
        t_pair;
        t_zero;
        print_verdict;
    end
    // about thirty times the expected run length
    initial
    begin
        #100000;
        err_total++;
        print_verdict;
    end
endmodule
